//--- hdl/grant_fifo.sv
`timescale 1ns/1ns
module grant_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;
  assign wr_ready_out = (wr_ptr_q - rd_ptr_q) != (AW+1)'(DEPTH);
  assign rd_valid_out = wr_ptr_q != rd_ptr_q;
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem_q[rd_ptr_q[AW-1:0]];
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule : grant_fifo

//--- hdl/grant_scheduler.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module grant_scheduler #(
  parameter int FIFO_DEPTH = 32,
  parameter int MAX_GRANTS = 15
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Upstream packet report from the modem
  input wire logic pkt_valid_in,
  input wire logic [3:0] pkt_active_grants_in,
  input wire logic pkt_queue_flag_in,
  input wire logic pkt_is_request_in,
  input wire logic [15:0] pkt_req_size_in,
  // Issued opportunities toward the map builder
  output logic grant_valid_out,
  output logic [15:0] grant_size_out,
  output logic grant_extra_out,
  output logic poll_valid_out,
  input wire logic map_ready_in
);
  initial begin
    if (MAX_GRANTS < 1 || MAX_GRANTS > 15) $error("MAX_GRANTS out of range");
  end
  // ******************************
  // Registers
  // ******************************
  logic ctrl_en_q;
  logic ctrl_ad_q;
  logic [31:0] interval_q;
  logic [31:0] jitter_q;
  logic [31:0] poll_q;
  logic [15:0] size_q;
  logic [3:0] maxg_q;
  logic [3:0] burst_cfg_q;
  grant_sched_pkg::sched_mode_t mode_q;
  logic [3:0] active_q;
  logic backlog_q;
  logic [31:0] timer_q;
  logic [3:0] pending_q;
  logic [3:0] burst_q;
  logic [6:0] extra_cnt_q;
  logic extra_due_q;
  logic [31:0] grants_issued_q;
  logic late_miss_q;
  logic [31:0] rd_d;
  logic wr_en;
  logic rd_en;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic fifo_pop;
  logic [3:0] req_count;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  always_comb begin
    pslverr_out = 1'b0;
    case (paddr_in)
      grant_sched_pkg::CTRL_OFS, grant_sched_pkg::INTERVAL_OFS,
      grant_sched_pkg::JITTER_OFS, grant_sched_pkg::POLL_OFS,
      grant_sched_pkg::SIZE_OFS, grant_sched_pkg::MAXG_OFS,
      grant_sched_pkg::BURST_OFS, grant_sched_pkg::STATUS_OFS,
      grant_sched_pkg::COUNT_OFS, grant_sched_pkg::FIFO_OFS: pslverr_out = 1'b0;
      default: pslverr_out = psel_in && penable_in;
    endcase
  end
  // Clamp a reported count to the configured maximum
  function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] m);
    clamp = (v > m) ? m : v;
  endfunction : clamp
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ctrl_en_q <= 1'b0;
      ctrl_ad_q <= 1'b0;
      interval_q <= grant_sched_pkg::INTERVAL_RST;
      jitter_q <= grant_sched_pkg::JITTER_RST;
      poll_q <= grant_sched_pkg::POLL_RST;
      size_q <= grant_sched_pkg::SIZE_RST;
      maxg_q <= grant_sched_pkg::MAXG_RST;
      burst_cfg_q <= grant_sched_pkg::BURST_RST;
    end else if (wr_en) begin
      case (paddr_in)
        grant_sched_pkg::CTRL_OFS: begin
          ctrl_en_q <= pwdata_in[grant_sched_pkg::CTRL_EN_BIT];
          ctrl_ad_q <= pwdata_in[grant_sched_pkg::CTRL_AD_BIT];
        end
        grant_sched_pkg::INTERVAL_OFS: interval_q <= (pwdata_in == 32'h0) ? 32'h1 : pwdata_in;
        grant_sched_pkg::JITTER_OFS: jitter_q <= pwdata_in;
        grant_sched_pkg::POLL_OFS: poll_q <= (pwdata_in == 32'h0) ? 32'h1 : pwdata_in;
        grant_sched_pkg::SIZE_OFS: size_q <= pwdata_in[15:0];
        grant_sched_pkg::MAXG_OFS: maxg_q <= clamp(pwdata_in[3:0], 4'(MAX_GRANTS));
        grant_sched_pkg::BURST_OFS: burst_cfg_q <= pwdata_in[3:0];
        default: ctrl_en_q <= ctrl_en_q;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= rd_d;
    end
  end
  always_comb begin
    case (paddr_in)
      grant_sched_pkg::CTRL_OFS: rd_d = {30'h0, ctrl_ad_q, ctrl_en_q};
      grant_sched_pkg::INTERVAL_OFS: rd_d = interval_q;
      grant_sched_pkg::JITTER_OFS: rd_d = jitter_q;
      grant_sched_pkg::POLL_OFS: rd_d = poll_q;
      grant_sched_pkg::SIZE_OFS: rd_d = {16'h0, size_q};
      grant_sched_pkg::MAXG_OFS: rd_d = {28'h0, maxg_q};
      grant_sched_pkg::BURST_OFS: rd_d = {28'h0, burst_cfg_q};
      grant_sched_pkg::STATUS_OFS: rd_d = {20'h0, late_miss_q, !fifo_in_ready, fifo_valid,
                                           backlog_q, active_q, 2'h0, mode_q};
      grant_sched_pkg::COUNT_OFS: rd_d = grants_issued_q;
      grant_sched_pkg::FIFO_OFS: rd_d = fifo_data;
      default: rd_d = 32'h0000_0000;
    endcase
  end
  // ******************************
  // Packet report FIFO
  // ******************************
  // Reports are logged for software; a full log drops entries, not scheduling
  grant_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .wr_data_in({10'h0, pkt_is_request_in, pkt_queue_flag_in, pkt_active_grants_in,
                 pkt_req_size_in}),
    .wr_valid_in(pkt_valid_in),
    .wr_ready_out(fifo_in_ready),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );
  assign fifo_pop = psel_in && penable_in && !pwrite_in && paddr_in == grant_sched_pkg::FIFO_OFS;
  // ******************************
  // Mode and pool tracking
  // ******************************
  logic pkt_take;
  // A full log must never hide a zero count or a cleared backlog flag
  assign pkt_take = pkt_valid_in;
  assign req_count = clamp(pkt_active_grants_in, maxg_q);
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      mode_q <= grant_sched_pkg::MODE_OFF;
      active_q <= 4'h0;
      burst_q <= 4'h0;
    end else if (!ctrl_en_q) begin
      mode_q <= grant_sched_pkg::MODE_OFF;
      active_q <= 4'h0;
      burst_q <= 4'h0;
    end else begin
      if (burst_q != 4'h0 && grant_valid_out && map_ready_in && pending_q == 4'h0) begin
        burst_q <= burst_q - 4'h1;
      end
      case (mode_q)
        grant_sched_pkg::MODE_OFF: begin
          mode_q <= ctrl_ad_q ? grant_sched_pkg::MODE_POLL : grant_sched_pkg::MODE_GRANT;
          active_q <= ctrl_ad_q ? 4'h0 : maxg_q;
        end
        grant_sched_pkg::MODE_POLL: begin
          if (pkt_take && (pkt_is_request_in || req_count != 4'h0)) begin
            // Request size ignored, configured size used
            mode_q <= grant_sched_pkg::MODE_GRANT;
            active_q <= (req_count == 4'h0) ? 4'h1 : req_count;
            burst_q <= burst_cfg_q;
          end
        end
        grant_sched_pkg::MODE_GRANT: begin
          if (pkt_take && ctrl_ad_q && !pkt_is_request_in) begin
            if (req_count == 4'h0) begin
              mode_q <= grant_sched_pkg::MODE_POLL;
              active_q <= 4'h0;
            end else begin
              if (req_count > active_q) begin
                burst_q <= burst_cfg_q;
              end
              active_q <= req_count;
            end
          end
        end
        default: mode_q <= grant_sched_pkg::MODE_OFF;
      endcase
    end
  end
  // Backlog flag follows the latest non-request packet
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      backlog_q <= 1'b0;
    end else if (pkt_take && !pkt_is_request_in) begin
      backlog_q <= pkt_queue_flag_in;
    end
  end
  // ******************************
  // Interval timer
  // ******************************
  // Free-running timer; the modem never learns its phase
  logic tick;
  logic [31:0] period;
  assign period = (mode_q == grant_sched_pkg::MODE_POLL) ? poll_q : interval_q;
  // Fire at nominal time every period; jitter only widens the late bound
  assign tick = timer_q == period - 32'h1;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      timer_q <= 32'h0;
    end else if (mode_q == grant_sched_pkg::MODE_OFF || tick) begin
      timer_q <= 32'h0;
    end else begin
      timer_q <= timer_q + 32'h1;
    end
  end
  // Cycles since the last tick, saturating; last grant must go by jitter plus active count
  logic [31:0] late_q;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      late_q <= 32'h0;
    end else if (tick) begin
      late_q <= 32'h0;
    end else if (late_q != 32'hFFFF_FFFF) begin
      late_q <= late_q + 32'h1;
    end
  end
  // ******************************
  // Jitter watch
  // ******************************
  // Sticky, since map stalls can push the last grant past the bound
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in || !ctrl_en_q) begin
      late_miss_q <= 1'b0;
    end else if (pending_q != 4'h0 && late_q > jitter_q + 32'(active_q)) begin
      late_miss_q <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pending_q <= 4'h0;
    end else if (mode_q != grant_sched_pkg::MODE_GRANT) begin
      pending_q <= 4'h0;
    end else if (tick) begin
      pending_q <= active_q;
    end else if (pending_q != 4'h0 && grant_valid_out && map_ready_in) begin
      pending_q <= pending_q - 4'h1;
    end
  end
  // ******************************
  // Extra grants for backlog
  // ******************************
  // Margin above provisioned rate soaks up clock mismatch
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      extra_cnt_q <= 7'h00;
      extra_due_q <= 1'b0;
    end else if (grant_valid_out && map_ready_in) begin
      if (grant_extra_out && !(burst_q != 4'h0)) begin
        extra_due_q <= 1'b0;
        extra_cnt_q <= 7'h00;
      end else if (!grant_extra_out) begin
        if (extra_cnt_q >= 7'(grant_sched_pkg::EXTRA_SPACING - 1)) begin
          extra_due_q <= backlog_q;
        end else begin
          extra_cnt_q <= extra_cnt_q + 7'h01;
        end
      end
    end
  end
  // ******************************
  // Issue
  // ******************************
  logic extra_now;
  assign extra_now = pending_q == 4'h0 && (burst_q != 4'h0 || (extra_due_q && backlog_q));
  assign grant_valid_out = mode_q == grant_sched_pkg::MODE_GRANT && (pending_q != 4'h0 ||
                           extra_now);
  assign grant_extra_out = pending_q == 4'h0;
  // One whole packet per grant of configured size
  assign grant_size_out = size_q;
  assign poll_valid_out = mode_q == grant_sched_pkg::MODE_POLL && tick;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      grants_issued_q <= 32'h0;
    end else if (grant_valid_out && map_ready_in) begin
      grants_issued_q <= grants_issued_q + 32'h1;
    end
  end
endmodule : grant_scheduler

//--- include/grant_sched_pkg.sv
// What this block does
// - Grants are issued at a steady spacing equal to the packet period.
// - Several subflows share one identifier, so several pooled grants per interval.
// - Each grant lands between nominal time and nominal time plus jitter; here a grant past jitter plus the active count only sets a sticky flag.
// - Each grant carries one whole packet, no concatenation or fragmentation.
// - While backlog flag is set, add at most one extra grant per hundred.
// - Head end polices downstream slightly above provisioned rate.
// - Idle activity-detected flow gets polls; active flow gets grants.
// - Each added grant per interval brings a burst of extra grants.
// - A zero-count packet moves the scheduler from grant mode to polling mode.
// - Size in a resume request is ignored; configured grant size is used.
// - Neither side relies on the grant interval boundary.
package grant_sched_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] INTERVAL_OFS = 8'h04;
  localparam logic [7:0] JITTER_OFS = 8'h08;
  localparam logic [7:0] POLL_OFS = 8'h0C;
  localparam logic [7:0] SIZE_OFS = 8'h10;
  localparam logic [7:0] MAXG_OFS = 8'h14;
  localparam logic [7:0] BURST_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] COUNT_OFS = 8'h20;
  localparam logic [7:0] FIFO_OFS = 8'h24;
  // Control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AD_BIT = 1;
  // Reset values; interval, jitter and poll periods in clock cycles at 50 MHz
  localparam int CLK_HZ = 50000000;
  localparam int INTERVAL_MS = 10;
  localparam logic [31:0] INTERVAL_RST = 32'(INTERVAL_MS * (CLK_HZ / 1000));
  localparam logic [31:0] JITTER_RST = 32'h0000_0000;
  localparam logic [31:0] POLL_RST = 32'(INTERVAL_MS * (CLK_HZ / 1000));
  localparam logic [15:0] SIZE_RST = 16'h0100;
  localparam logic [3:0] MAXG_RST = 4'h1;
  localparam logic [3:0] BURST_RST = 4'h2;
  localparam int EXTRA_SPACING = 100;
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_POLL = 2'b01,
    MODE_GRANT = 2'b10
  } sched_mode_t;
endpackage : grant_sched_pkg

//--- tb/grant_sched_props.sv
`timescale 1ns/1ns
module grant_sched_props #(
  parameter int FIFO_DEPTH = 32,
  parameter int MAX_GRANTS = 15
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pkt_valid_in,
  input wire logic [3:0] pkt_active_grants_in,
  input wire logic pkt_is_request_in,
  input wire logic grant_valid_out,
  input wire logic [15:0] grant_size_out,
  input wire logic grant_extra_out,
  input wire logic poll_valid_out,
  input wire logic map_ready_in
);
  // ****************
  // Shadow state
  // ****************
  logic [15:0] size_q;
  logic [1:0] ctrl_q;
  logic [7:0] norm_cnt_q;
  logic wr;
  logic taken;
  assign wr = psel_in && penable_in && pwrite_in;
  assign taken = grant_valid_out && map_ready_in;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      size_q <= grant_sched_pkg::SIZE_RST;
      ctrl_q <= 2'h0;
    end else if (wr && paddr_in == grant_sched_pkg::SIZE_OFS) begin
      size_q <= pwdata_in[15:0];
    end else if (wr && paddr_in == grant_sched_pkg::CTRL_OFS) begin
      ctrl_q <= pwdata_in[1:0];
    end
  end
  // Saturates, so a long quiet spell never wraps
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in || (taken && grant_extra_out)) begin
      norm_cnt_q <= 8'h00;
    end else if (taken && norm_cnt_q != 8'hFF) begin
      norm_cnt_q <= norm_cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_zero_pkt;
    ctrl_q == 2'h3 && pkt_valid_in && !pkt_is_request_in && pkt_active_grants_in == 4'h0;
  endsequence
  sequence s_req_pkt;
    ctrl_q == 2'h3 && pkt_valid_in && pkt_is_request_in;
  endsequence
  a_grant_held: assert property (
    grant_valid_out && !map_ready_in |=> grant_valid_out && $stable(grant_size_out))
    else $error("grant dropped before taken");
  a_size_config: assert property (grant_valid_out |-> grant_size_out == size_q)
    else $error("grant size differs from setting");
  a_poll_single: assert property (poll_valid_out |=> !poll_valid_out [*8])
    else $error("poll pulse too long");
  a_mode_exclusive: assert property (!(grant_valid_out && poll_valid_out))
    else $error("grant and poll together");
  a_off_quiet: assert property (!ctrl_q[0] [*3] |-> !grant_valid_out && !poll_valid_out)
    else $error("activity while disabled");
  a_zero_stops: assert property (s_zero_pkt |-> ##[1:3] !grant_valid_out [*8])
    else $error("grants go on after zero count");
  a_req_burst: assert property (s_req_pkt |-> ##[1:40] grant_valid_out && grant_extra_out)
    else $error("no burst after request");
  a_extra_spacing: assert property (
    ctrl_q == 2'h1 && taken && grant_extra_out |-> norm_cnt_q >= 8'(grant_sched_pkg::EXTRA_SPACING - 1))
    else $error("extra grants too close");
endmodule : grant_sched_props
bind grant_scheduler grant_sched_props #(.FIFO_DEPTH(FIFO_DEPTH), .MAX_GRANTS(MAX_GRANTS)) props (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pkt_valid_in(pkt_valid_in),
  .pkt_active_grants_in(pkt_active_grants_in), .pkt_is_request_in(pkt_is_request_in),
  .grant_valid_out(grant_valid_out), .grant_size_out(grant_size_out),
  .grant_extra_out(grant_extra_out), .poll_valid_out(poll_valid_out), .map_ready_in(map_ready_in)
);

//--- tb/modem_model.sv
`timescale 1ns/1ns
module modem_model #(
  parameter logic [3:0] MAX_NEED = 4'h3
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] active_in,
  input wire logic backlog_in,
  input wire logic flood_in,
  input wire logic grant_valid_in,
  input wire logic map_ready_in,
  input wire logic poll_valid_in,
  output logic pkt_valid_out,
  output logic [3:0] pkt_active_grants_out,
  output logic pkt_queue_flag_out,
  output logic pkt_is_request_out,
  output logic [15:0] pkt_req_size_out
);
  logic zero_sent_q;
  logic [5:0] flood_q;
  logic [3:0] need;
  assign need = (active_in > MAX_NEED) ? MAX_NEED : active_in;
  always_ff @(posedge ref_clk_in) begin
    pkt_valid_out <= 1'b0;
    pkt_is_request_out <= 1'b0;
    pkt_active_grants_out <= ~pkt_active_grants_out;
    pkt_req_size_out <= ~pkt_req_size_out;
    pkt_queue_flag_out <= backlog_in;
    if (!rstn_in) begin
      zero_sent_q <= 1'b0;
      flood_q <= 6'h00;
      pkt_active_grants_out <= 4'h0;
      pkt_req_size_out <= 16'h0000;
    end else if (flood_q != 6'h00) begin
      flood_q <= flood_q - 6'h01;
      pkt_valid_out <= 1'b1;
      pkt_active_grants_out <= need;
    end else if (flood_in) begin
      flood_q <= 6'h28;
    end else if (grant_valid_in && map_ready_in && (need != 4'h0 || !zero_sent_q)) begin
      // One whole packet per pooled grant, slot unknown
      pkt_valid_out <= 1'b1;
      pkt_active_grants_out <= need;
      zero_sent_q <= (need == 4'h0);
    end else if (poll_valid_in && need != 4'h0) begin
      // Size is junk on purpose; head end must ignore it
      pkt_valid_out <= 1'b1;
      pkt_is_request_out <= 1'b1;
      pkt_active_grants_out <= need;
      pkt_req_size_out <= 16'h0FFF;
      zero_sent_q <= 1'b0;
    end
  end
endmodule : modem_model

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] rst;} row_t;
  logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pkt_valid, pkt_flag, pkt_req, grant_valid, grant_extra, poll_valid;
  logic [3:0] pkt_ag;
  logic [15:0] pkt_size, grant_size;
  logic map_ready = 1'b1, backlog = 1'b0, flood = 1'b0;
  logic [3:0] active = 4'h1;
  int fails = 0, checked = 0, n_norm = 0, n_extra = 0, n_poll = 0;
  row_t rows [6];
  always #10 ref_clk = ~ref_clk;
  grant_scheduler #(.FIFO_DEPTH(32), .MAX_GRANTS(15)) dut (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pkt_valid_in(pkt_valid),
    .pkt_active_grants_in(pkt_ag), .pkt_queue_flag_in(pkt_flag), .pkt_is_request_in(pkt_req),
    .pkt_req_size_in(pkt_size), .grant_valid_out(grant_valid), .grant_size_out(grant_size),
    .grant_extra_out(grant_extra), .poll_valid_out(poll_valid), .map_ready_in(map_ready));
  modem_model #(.MAX_NEED(4'h3)) partner (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .active_in(active), .backlog_in(backlog),
    .flood_in(flood), .grant_valid_in(grant_valid), .map_ready_in(map_ready),
    .poll_valid_in(poll_valid), .pkt_valid_out(pkt_valid), .pkt_active_grants_out(pkt_ag),
    .pkt_queue_flag_out(pkt_flag), .pkt_is_request_out(pkt_req), .pkt_req_size_out(pkt_size));
  always @(posedge ref_clk) begin
    if (grant_valid === 1'b1 && map_ready) begin
      if (grant_extra === 1'b1) n_extra <= n_extra + 1;
      else n_norm <= n_norm + 1;
    end
    if (poll_valid === 1'b1) n_poll <= n_poll + 1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic gap(input int n, output int cyc);
    int start;
    start = n_norm;
    cyc = 0;
    while (n_norm < start + n) begin
      @(posedge ref_clk);
      cyc++;
    end
  endtask : gap
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    logic [31:0] rd;
    logic er;
    int cyc, e0, n0, p0;
    rows[0] = '{grant_sched_pkg::INTERVAL_OFS, 32'h14, grant_sched_pkg::INTERVAL_RST};
    rows[1] = '{grant_sched_pkg::POLL_OFS, 32'h14, grant_sched_pkg::POLL_RST};
    rows[2] = '{grant_sched_pkg::SIZE_OFS, 32'h0123, 32'(grant_sched_pkg::SIZE_RST)};
    rows[3] = '{grant_sched_pkg::MAXG_OFS, 32'h3, 32'(grant_sched_pkg::MAXG_RST)};
    rows[4] = '{grant_sched_pkg::BURST_OFS, 32'h2, 32'(grant_sched_pkg::BURST_RST)};
    rows[5] = '{grant_sched_pkg::JITTER_OFS, 32'h0, grant_sched_pkg::JITTER_RST};
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0, rd, er);
      chk("reset value", rows[i].rst, rd);
      apb(1'b1, rows[i].addr, rows[i].wdata, rd, er);
      apb(1'b0, rows[i].addr, 32'h0, rd, er);
      chk("read back", rows[i].wdata, rd);
    end
    apb(1'b0, 8'h40, 32'h0, rd, er);
    chk("unmapped error", 32'h1, 32'(er));
    apb(1'b1, grant_sched_pkg::CTRL_OFS, 32'h1, rd, er);
    repeat (3) gap(3, cyc);
    chk("grant spacing", 32'h14, 32'(cyc));
    apb(1'b0, grant_sched_pkg::STATUS_OFS, 32'h0, rd, er);
    chk("late flag clear", 32'h0, 32'(rd[11]));
    chk("grant size", 32'h0123, 32'(grant_size));
    map_ready <= 1'b0;
    repeat (30) @(posedge ref_clk);
    map_ready <= 1'b1;
    apb(1'b0, grant_sched_pkg::STATUS_OFS, 32'h0, rd, er);
    chk("late flag set", 32'h1, 32'(rd[11]));
    backlog <= 1'b1;
    e0 = n_extra;
    n0 = n_norm;
    while (n_norm < n0 + 250) @(posedge ref_clk);
    chk("backlog extras", 32'h1, 32'(n_extra - e0 >= 2 && n_extra - e0 <= 3));
    backlog <= 1'b0;
    repeat (60) @(posedge ref_clk);
    e0 = n_extra;
    n0 = n_norm;
    while (n_norm < n0 + 110) @(posedge ref_clk);
    chk("extras after clear", 32'(e0), 32'(n_extra));
    apb(1'b1, grant_sched_pkg::CTRL_OFS, 32'h3, rd, er);
    repeat (60) @(posedge ref_clk);
    active <= 4'h0;
    repeat (80) @(posedge ref_clk);
    n0 = n_norm;
    p0 = n_poll;
    repeat (60) @(posedge ref_clk);
    chk("grants when idle", 32'(n0), 32'(n_norm));
    chk("polls when idle", 32'h1, 32'(n_poll - p0 >= 2));
    e0 = n_extra;
    n0 = n_norm;
    active <= 4'h5;
    repeat (100) @(posedge ref_clk);
    chk("resume burst", 32'h1, 32'(n_extra - e0 >= 2));
    chk("resume grants", 32'h1, 32'(n_norm - n0 >= 2));
    // Stop grants first so only flooded reports reach the log
    apb(1'b1, grant_sched_pkg::CTRL_OFS, 32'h0, rd, er);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, grant_sched_pkg::STATUS_OFS, 32'h0, rd, er);
    for (int k = 0; k < 64 && rd[9]; k++) begin
      apb(1'b0, grant_sched_pkg::FIFO_OFS, 32'h0, rd, er);
      apb(1'b0, grant_sched_pkg::STATUS_OFS, 32'h0, rd, er);
    end
    flood <= 1'b1;
    @(posedge ref_clk);
    flood <= 1'b0;
    repeat (60) @(posedge ref_clk);
    for (int k = 0; k < 31; k++) apb(1'b0, grant_sched_pkg::FIFO_OFS, 32'h0, rd, er);
    apb(1'b0, grant_sched_pkg::STATUS_OFS, 32'h0, rd, er);
    chk("log last entry", 32'h1, 32'(rd[9]));
    apb(1'b0, grant_sched_pkg::FIFO_OFS, 32'h0, rd, er);
    apb(1'b0, grant_sched_pkg::STATUS_OFS, 32'h0, rd, er);
    chk("log drained", 32'h0, 32'(rd[9]));
    report_and_stop();
  end
endmodule : tb
